// file: shared/rbat_pkg.sv
// package: constants and types for the register bit access library
package rbat_pkg;
	localparam int                     RBAT_WIDTH = 8;
	localparam logic [RBAT_WIDTH-1:0] RBAT_ZERO  = 8'h00;
	// reset values of the bit kinds' storage, RBAT_RST_LLOW aside: both latches load RBAT_RST_LHIGH
	localparam logic [RBAT_WIDTH-1:0] RBAT_RST_CTRL  = 8'h00;
	localparam logic [RBAT_WIDTH-1:0] RBAT_RST_STICK = 8'h00;
	localparam logic [RBAT_WIDTH-1:0] RBAT_RST_LLOW  = 8'hff;
	localparam logic [RBAT_WIDTH-1:0] RBAT_RST_LHIGH = 8'h00;
	localparam logic [RBAT_WIDTH-1:0] RBAT_RST_SELF  = 8'h00;
	// field select codes
	typedef enum logic [2:0] {
		RBAT_SEL_RO    = 3'h0,
		RBAT_SEL_COR   = 3'h1,
		RBAT_SEL_WO    = 3'h3,
		RBAT_SEL_W1C   = 3'h2,
		RBAT_SEL_W0C   = 3'h6,
		RBAT_SEL_LLOW  = 3'h7,
		RBAT_SEL_LHIGH = 3'h5,
		RBAT_SEL_SELF  = 3'h4
	} rbat_sel_t;
	// self-clearing bit lifecycle
	typedef enum logic [1:0] {
		RBAT_SC_IDLE = 2'h0,
		RBAT_SC_SET  = 2'h1,
		RBAT_SC_DONE = 2'h3
	} rbat_sc_t;
endpackage : rbat_pkg

// file: shared/rbat_acc_if.sv
// interface: host access strobes shared by the bit access modules
interface rbat_acc_if;
	import rbat_pkg::*;
	logic                  wrEn;
	logic                  rdEn;
	rbat_sel_t             sel;
	logic [RBAT_WIDTH-1:0] wrData;
	modport host (output wrEn, output rdEn, output sel, output wrData);
	modport bits (input wrEn, input rdEn, input sel, input wrData);
endinterface : rbat_acc_if

// file: rtl/rbat_self_clear.sv
// module: self-clearing bits with launch handshake
module rbat_self_clear
	import rbat_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  rst_b,
	rbat_acc_if.bits                   acc,
	input  wire logic [RBAT_WIDTH-1:0] launched,
	output logic      [RBAT_WIDTH-1:0] selfBits
);
	import rbat_pkg::*;

	logic [RBAT_WIDTH-1:0] selfQ;
	logic [RBAT_WIDTH-1:0] selfD;
	logic                  wrHit;

	assign wrHit = acc.wrEn && acc.sel == RBAT_SEL_SELF;
	// writing zero never clears; only the launch acknowledge does
	// a bit stays set until its action is launched, at least one cycle
	assign selfD = (selfQ & ~launched) | (wrHit ? acc.wrData : RBAT_ZERO);
	assign selfBits = selfQ;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			selfQ <= RBAT_RST_SELF;
		end else begin
			selfQ <= selfD;
		end
	end

	chk_self_held: assert property (@(posedge core_clk) disable iff (!rst_b)
		wrHit && acc.wrData[0] |=> selfQ[0])
		else $error("self-clearing bit not set after write");
	chk_self_drop: assert property (@(posedge core_clk) disable iff (!rst_b)
		selfQ[0] && launched[0] && !(wrHit && acc.wrData[0]) |=> !selfQ[0])
		else $error("self-clearing bit did not drop after launch");
	chk_self_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
		selfQ[0] && !launched[0] |=> selfQ[0])
		else $error("self-clearing bit dropped without launch");
	cov_self_cycle: cover property (@(posedge core_clk) disable iff (!rst_b)
		wrHit ##1 selfQ[0] ##[1:4] !selfQ[0]);
endmodule : rbat_self_clear

// file: rtl/rbat_bit_bank.sv
// module: bank of register bits, one field per access kind
module rbat_bit_bank
	import rbat_pkg::*;
(
	input  wire logic                  core_clk,
	input  wire logic                  rst_b,
	input  wire logic                  wrEn,
	input  wire logic                  rdEn,
	input  wire rbat_pkg::rbat_sel_t   sel,
	input  wire logic [RBAT_WIDTH-1:0] wrData,
	output logic      [RBAT_WIDTH-1:0] rdData,
	input  wire logic [RBAT_WIDTH-1:0] roStatus,
	input  wire logic [RBAT_WIDTH-1:0] corSet,
	input  wire logic [RBAT_WIDTH-1:0] w1cSet,
	input  wire logic [RBAT_WIDTH-1:0] w0cSet,
	input  wire logic [RBAT_WIDTH-1:0] lowStatus,
	input  wire logic [RBAT_WIDTH-1:0] highStatus,
	input  wire logic [RBAT_WIDTH-1:0] launched,
	output logic      [RBAT_WIDTH-1:0] woCtrl,
	output logic      [RBAT_WIDTH-1:0] selfBits
);
	import rbat_pkg::*;

	function automatic logic hit(input logic en, input rbat_sel_t s, input rbat_sel_t want);
		hit = en && (s == want);
	endfunction : hit

	rbat_acc_if acc ();
	assign acc.wrEn   = wrEn;
	assign acc.rdEn   = rdEn;
	assign acc.sel    = sel;
	assign acc.wrData = wrData;

	logic [RBAT_WIDTH-1:0] corQ, corD, w1cQ, w1cD, w0cQ, w0cD;
	logic [RBAT_WIDTH-1:0] llHeldQ, llHeldD, lhHeldQ, lhHeldD;
	logic [RBAT_WIDTH-1:0] woQ, lowView, highView, rdD, rdQ;
	logic                  rdCor, rdLl, rdLh, wrW1c, wrW0c, wrWo;
	logic                  wrSelf;

	assign rdCor = hit(rdEn, sel, RBAT_SEL_COR);
	assign rdLl  = hit(rdEn, sel, RBAT_SEL_LLOW);
	assign rdLh  = hit(rdEn, sel, RBAT_SEL_LHIGH);
	assign wrW1c = hit(wrEn, sel, RBAT_SEL_W1C);
	assign wrW0c = hit(wrEn, sel, RBAT_SEL_W0C);
	assign wrWo  = hit(wrEn, sel, RBAT_SEL_WO);
	// only watched by the checks below; the submodule decodes its own hit
	assign wrSelf = hit(wrEn, sel, RBAT_SEL_SELF);

	// clear-on-read: read empties, writes ignored, new event survives
	assign corD = (rdCor ? RBAT_ZERO : corQ) | corSet;
	// set wins over a same-cycle clear
	assign w1cD = (wrW1c ? (w1cQ & ~wrData) : w1cQ) | w1cSet;
	assign w0cD = (wrW0c ? (w0cQ & wrData) : w0cQ) | w0cSet;
	// latch records a past event; view combines live level and latch
	// a read releases the latch unless the event is still present
	assign llHeldD  = (rdLl ? RBAT_ZERO : llHeldQ) | ~lowStatus;
	assign lhHeldD  = (rdLh ? RBAT_ZERO : lhHeldQ) | highStatus;
	assign lowView  = lowStatus & ~llHeldQ;
	assign highView = highStatus | lhHeldQ;

	// write-only reads give zero; host must not rely on it
	always_comb begin
		rdD = RBAT_ZERO;
		unique case (sel)
			RBAT_SEL_RO:    rdD = roStatus;
			RBAT_SEL_COR:   rdD = corQ;
			RBAT_SEL_WO:    rdD = RBAT_ZERO;
			RBAT_SEL_W1C:   rdD = w1cQ;
			RBAT_SEL_W0C:   rdD = w0cQ;
			RBAT_SEL_LLOW:  rdD = lowView;
			RBAT_SEL_LHIGH: rdD = highView;
			RBAT_SEL_SELF:  rdD = selfBits;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			corQ    <= RBAT_RST_STICK;
			w1cQ    <= RBAT_RST_STICK;
			w0cQ    <= RBAT_RST_STICK;
			llHeldQ <= RBAT_RST_LHIGH;
			lhHeldQ <= RBAT_RST_LHIGH;
			woQ     <= RBAT_RST_CTRL;
			rdQ     <= RBAT_ZERO;
		end else begin
			corQ    <= corD;
			w1cQ    <= w1cD;
			w0cQ    <= w0cD;
			llHeldQ <= llHeldD;
			lhHeldQ <= lhHeldD;
			woQ     <= wrWo ? wrData : woQ;
			rdQ     <= rdEn ? rdD : rdQ;
		end
	end

	assign woCtrl = woQ;
	// registered data, valid the cycle after rdEn
	assign rdData = rdQ;

	rbat_self_clear u_self (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.acc      (acc),
		.launched (launched),
		.selfBits (selfBits)
	);

	chk_ro_read: assert property (@(posedge core_clk) disable iff (!rst_b)
		rdEn && sel == RBAT_SEL_RO |=> rdData == $past(roStatus))
		else $error("read-only read mismatch");
	chk_cor_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
		rdCor |=> rdData == $past(corQ) && corQ == $past(corSet))
		else $error("clear-on-read did not clear");
	chk_wo_store: assert property (@(posedge core_clk) disable iff (!rst_b)
		wrWo |=> woCtrl == $past(wrData))
		else $error("write-only value not stored");
	chk_w1c_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
		wrW1c && wrData[0] && !w1cSet[0] |=> !w1cQ[0])
		else $error("write-one-to-clear failed");
	chk_w0c_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
		wrW0c && !wrData[0] && !w0cSet[0] |=> !w0cQ[0])
		else $error("write-zero-to-clear failed");
	chk_ll_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		!lowStatus[0] && !rdLl ##1 !rdLl [*2] |-> !lowView[0])
		else $error("latched low released early");
	chk_lh_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		highStatus[0] && !rdLh ##1 !rdLh [*2] |-> highView[0])
		else $error("latched high released early");
	chk_lh_release: assert property (@(posedge core_clk) disable iff (!rst_b)
		rdLh && !highStatus[0] |=> highView[0] == highStatus[0])
		else $error("latch not released by read");
	chk_set_wins: assert property (@(posedge core_clk) disable iff (!rst_b)
		(rdCor && corSet[0]) or (wrW1c && w1cSet[0]) |=> corQ[0] || w1cQ[0])
		else $error("event lost to same-cycle clear");


	// read data only moves on a read strobe
	chk_rd_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		!rdEn |=> rdData == $past(rdData))
		else $error("read data changed without a read");

	// sticky and write-only fields: nothing but a clear, a set or a write may move them
	chk_cor_nowrite: assert property (@(posedge core_clk) disable iff (!rst_b)
		!rdCor && corSet == RBAT_ZERO |=> corQ == $past(corQ))
		else $error("clear-on-read field moved without read or event");
	chk_cor_set: assert property (@(posedge core_clk) disable iff (!rst_b)
		corSet[0] |=> corQ[0])
		else $error("clear-on-read event lost");
	chk_wo_keep: assert property (@(posedge core_clk) disable iff (!rst_b)
		!wrWo |=> woCtrl == $past(woCtrl))
		else $error("write-only field moved without write");

	// a written zero or one that is not the clearing value changes nothing
	chk_w1c_keep: assert property (@(posedge core_clk) disable iff (!rst_b)
		wrW1c && !wrData[0] && !w1cSet[0] |=> w1cQ[0] == $past(w1cQ[0]))
		else $error("write-one-to-clear changed on zero write");
	chk_w0c_keep: assert property (@(posedge core_clk) disable iff (!rst_b)
		wrW0c && wrData[0] && !w0cSet[0] |=> w0cQ[0] == $past(w0cQ[0]))
		else $error("write-zero-to-clear changed on one write");
	chk_w1c_set: assert property (@(posedge core_clk) disable iff (!rst_b)
		w1cSet[0] |=> w1cQ[0])
		else $error("write-one-to-clear event lost");
	chk_w0c_set: assert property (@(posedge core_clk) disable iff (!rst_b)
		w0cSet[0] |=> w0cQ[0])
		else $error("write-zero-to-clear event lost");

	// latches catch an event even when a read lands in the same cycle
	chk_ll_catch: assert property (@(posedge core_clk) disable iff (!rst_b)
		!lowStatus[0] |=> !lowView[0])
		else $error("latched low missed an event");
	chk_lh_catch: assert property (@(posedge core_clk) disable iff (!rst_b)
		highStatus[0] |=> highView[0])
		else $error("latched high missed an event");
	chk_ll_release: assert property (@(posedge core_clk) disable iff (!rst_b)
		rdLl && lowStatus[0] |=> lowView[0] == lowStatus[0])
		else $error("latched low not released by read");

	// a set write always lands, whatever the launch acknowledge does
	chk_self_write: assert property (@(posedge core_clk) disable iff (!rst_b)
		wrSelf |=> (selfBits & $past(wrData)) == $past(wrData))
		else $error("self-clearing write lost");

	cov_cor_read: cover property (@(posedge core_clk) disable iff (!rst_b) corQ[0] ##1 rdCor);
	cov_ll_event: cover property (@(posedge core_clk) disable iff (!rst_b)
		!lowStatus[0] ##1 lowStatus[0] ##1 rdLl);
	cov_lh_event: cover property (@(posedge core_clk) disable iff (!rst_b)
		highStatus[0] ##1 !highStatus[0] ##1 rdLh);
	cov_set_clash: cover property (@(posedge core_clk) disable iff (!rst_b) wrW1c && w1cSet[0]);
endmodule : rbat_bit_bank

// file: testbench/register_bit_access_types_tb.sv
// testbench: self-checking bench for the register bit bank
module register_bit_access_types_tb;
	import rbat_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic                  core_clk   = 1'b0;
	logic                  rst_b      = 1'b0;
	logic                  wrEn       = 1'b0;
	logic                  rdEn       = 1'b0;
	rbat_sel_t             sel        = RBAT_SEL_RO;
	logic [RBAT_WIDTH-1:0] wrData     = 8'h00; // data starts at zero, as reserved bits want; after a write it keeps the written value
	logic [RBAT_WIDTH-1:0] roStatus   = 8'h00;
	logic [RBAT_WIDTH-1:0] corSet     = 8'h00;
	logic [RBAT_WIDTH-1:0] w1cSet     = 8'h00;
	logic [RBAT_WIDTH-1:0] w0cSet     = 8'h00;
	logic [RBAT_WIDTH-1:0] lowStatus  = 8'hff;
	logic [RBAT_WIDTH-1:0] highStatus = 8'h00;
	logic [RBAT_WIDTH-1:0] launched   = 8'h00;
	logic [RBAT_WIDTH-1:0] rdData;
	logic [RBAT_WIDTH-1:0] woCtrl;
	logic [RBAT_WIDTH-1:0] selfBits;
	logic [RBAT_WIDTH-1:0] expQ[$];
	logic                  rdPend     = 1'b0;
	logic [31:0]           seed       = 32'h99c4d8ab;
	int                    failures   = 0;
	int                    check_count = 0;
	int                    n;

	always #25 core_clk = ~core_clk;

	rbat_bit_bank uut (.core_clk(core_clk), .rst_b(rst_b), .wrEn(wrEn), .rdEn(rdEn),
		.sel(sel), .wrData(wrData), .rdData(rdData), .roStatus(roStatus), .corSet(corSet),
		.w1cSet(w1cSet), .w0cSet(w0cSet), .lowStatus(lowStatus), .highStatus(highStatus),
		.launched(launched), .woCtrl(woCtrl), .selfBits(selfBits));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input string what, input logic [RBAT_WIDTH-1:0] seen,
		input logic [RBAT_WIDTH-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input rbat_sel_t s, input logic [RBAT_WIDTH-1:0] d);
		@(posedge core_clk);
		wrEn   <= 1'b1;
		sel    <= s;
		wrData <= d;
		@(posedge core_clk);
		wrEn <= 1'b0;
	endtask : wr

	// expectation is queued by the driver, the monitor takes it two cycles later
	task automatic rd(input rbat_sel_t s, input logic [RBAT_WIDTH-1:0] exp);
		@(posedge core_clk);
		rdEn <= 1'b1;
		sel  <= s;
		expQ.push_back(exp);
		@(posedge core_clk);
		rdEn <= 1'b0;
	endtask : rd

	task automatic wrap_up();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	// read data is registered, so it is compared one edge after the read is taken
	always @(posedge core_clk) begin
		if (rdPend) check("rdData", rdData, expQ.pop_front());
		rdPend <= rdEn;
	end

	initial begin
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		seed = lfsr(seed);
		roStatus <= seed[7:0];
		wr(RBAT_SEL_RO, ~seed[7:0]);
		rd(RBAT_SEL_RO, seed[7:0]);
		$display("test read only done");
		corSet <= 8'h5a;
		@(posedge core_clk);
		corSet <= 8'h00;
		wr(RBAT_SEL_COR, 8'hff);
		rd(RBAT_SEL_COR, 8'h5a);
		rd(RBAT_SEL_COR, 8'h00);
		$display("test clear on read done");
		seed = lfsr(seed);
		wr(RBAT_SEL_WO, seed[7:0]);
		@(negedge core_clk);
		check("woCtrl", woCtrl, seed[7:0]);
		rd(RBAT_SEL_WO, 8'h00);
		$display("test write only done");
		w1cSet <= 8'hff;
		@(posedge core_clk);
		w1cSet <= 8'h00;
		wr(RBAT_SEL_W1C, 8'h0f);
		rd(RBAT_SEL_W1C, 8'hf0);
		// set event held across the clearing write must survive it
		w1cSet <= 8'h01;
		wr(RBAT_SEL_W1C, 8'hff);
		w1cSet <= 8'h00;
		rd(RBAT_SEL_W1C, 8'h01);
		$display("test write one to clear done");
		w0cSet <= 8'hff;
		@(posedge core_clk);
		w0cSet <= 8'h00;
		wr(RBAT_SEL_W0C, 8'h0f);
		rd(RBAT_SEL_W0C, 8'h0f);
		$display("test write zero to clear done");
		lowStatus <= 8'hf0;
		@(posedge core_clk);
		lowStatus <= 8'hff;
		rd(RBAT_SEL_LLOW, 8'hf0);
		rd(RBAT_SEL_LLOW, 8'hff);
		highStatus <= 8'h3c;
		@(posedge core_clk);
		highStatus <= 8'h00;
		rd(RBAT_SEL_LHIGH, 8'h3c);
		rd(RBAT_SEL_LHIGH, 8'h00);
		$display("test latched status done");
		wr(RBAT_SEL_SELF, 8'h81);
		repeat (3) @(negedge core_clk);
		check("selfBits", selfBits, 8'h81);
		rd(RBAT_SEL_SELF, 8'h81);
		launched <= 8'h81;
		@(posedge core_clk);
		launched <= 8'h00;
		@(negedge core_clk);
		for (n = 0; n < 4 && selfBits !== 8'h00; n++) @(negedge core_clk);
		check("selfBits", selfBits, 8'h00);
		if (n == 4) wrap_up();
		wr(RBAT_SEL_SELF, 8'h00);
		@(negedge core_clk);
		check("selfBits", selfBits, 8'h00);
		$display("test self clearing done");
		repeat (2) @(posedge core_clk);
		wrap_up();
	end
endmodule : register_bit_access_types_tb
